/* File: rtl/cmp_event_pkg.sv */
package cmp_event_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] REF_CTRL_IDX = 8'hAF;
  localparam logic [7:0] B_CTRL_IDX = 8'h9F;
  localparam logic [7:0] A_CTRL_IDX = 8'h97;
  localparam logic [7:0] IRQ_STAT_IDX = 8'hC0;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hC1;
  // Reset values
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [7:0] B_CTRL_RST = 8'hC0;
  localparam logic [7:0] A_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  // Field positions in the comparator B control/status register
  localparam int B_POS_LSB = 6;
  localparam int B_CONN_BIT = 5;
  localparam int B_FLAG_BIT = 4;
  localparam int B_EN_BIT = 3;
  localparam int B_MODE_LSB = 0;
  // Field positions in the comparator A control register
  localparam int A_CONN_BIT = 5;
  // Field positions in the reference control register
  localparam int B_CLK_LSB = 6;
  localparam int B_NEG_LSB = 4;
  localparam int A_CLK_LSB = 2;
  localparam int A_NEG_LSB = 0;
  // Interrupt status bit of the comparator B event
  localparam int IRQ_B_BIT = 0;
  // Interrupt mode codes
  localparam logic [2:0] MODE_LOW = 3'h0;
  localparam logic [2:0] MODE_RISE = 3'h1;
  localparam logic [2:0] MODE_DB_TOG = 3'h2;
  localparam logic [2:0] MODE_DB_RISE = 3'h3;
  localparam logic [2:0] MODE_FALL = 3'h4;
  localparam logic [2:0] MODE_TOG = 3'h5;
  localparam logic [2:0] MODE_DB_FALL = 3'h6;
  localparam logic [2:0] MODE_HIGH = 3'h7;
  // Sampling clock codes
  localparam logic [1:0] CLK_SYS = 2'h0;
  localparam logic [1:0] CLK_T0 = 2'h1;
  localparam logic [1:0] CLK_T1 = 2'h2;
  localparam logic [1:0] CLK_T2 = 2'h3;
  // Negative input codes
  localparam logic [1:0] NEG_PIN = 2'h0;
  localparam logic [1:0] NEG_REF_LO = 2'h1;
  localparam logic [1:0] NEG_REF = 2'h2;
  localparam logic [1:0] NEG_REF_HI = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2;
  } timer_ovf_t;

  typedef struct packed {
    logic [1:0] b_pos_sel;
    logic [1:0] b_neg_sel;
    logic [1:0] a_neg_sel;
    logic b_connect;
    logic a_connect;
    logic [3:0] pin_dig_off;
    logic [3:0] pin_input_only;
  } analog_ctl_t;

  typedef struct packed {
    logic [7:0] ref_ctrl;
    logic [7:0] b_ctrl;
    logic [7:0] a_ctrl;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [31:0] rdata;
    logic [7:0] rd_stat;
    logic b_out;
    logic b_smp;
    logic db_raw;
    logic db_val;
    logic a_smp;
    logic irq;
  } state_t;
endpackage

/* File: rtl/comparator_event_control.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Disabled: output low, no new flags
// - Enabled: pins analog, input-only, digital off
// - Three-bit mode picks flag condition
// - Debounced modes sample on Timer 1
// - Per-comparator sampling clock select fields
// - B negative input from four sources
// - A negative input from four sources
// - Reference control resets to zero
// - Flag sticky until software clears
// - Connect bit joins pins to comparator
module comparator_event_control (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire cmp_event_pkg::apb_req_t apb_req, // APB request
  output cmp_event_pkg::apb_rsp_t apb_rsp, // APB answer
  input wire cmp_event_pkg::timer_ovf_t ovf, // Timer overflow pulses
  input wire logic comp_b_in, // Raw comparator B output
  input wire logic comp_a_in, // Raw comparator A output
  output logic comp_b_out, // Gated comparator B output
  output logic comp_a_sampled, // Comparator A on its tick
  output cmp_event_pkg::analog_ctl_t analog_ctl, // Analog steering
  output logic comparator_b_flag, // Sticky event flag
  output logic irq // Level interrupt
);
  import cmp_event_pkg::*;

  state_t st;
  state_t nxt;
  // Bus decode
  logic setup;
  logic access;
  logic hit;
  // One select line per mapped register
  logic hit_ref;
  logic hit_b;
  logic hit_a;
  logic hit_stat;
  logic hit_mask;
  // Read and write strobes of the access phase
  logic wr_acc;
  logic rd_acc;
  logic [7:0] idx;
  // Comparator B event path
  logic en;
  logic [2:0] mode;
  logic gated;
  logic b_tick;
  logic a_tick;
  logic rise;
  logic fall;
  logic db_ok;
  logic db_rise;
  logic db_fall;
  logic cond;
  logic ev;
  logic [7:0] wbyte;

  // Sampling tick for a clock-select code
  function automatic logic sel_tick(input logic [1:0] sel, input timer_ovf_t o);
    logic t;
    case (sel)
      CLK_SYS: begin
        t = 1'b1;
      end
      CLK_T0: begin
        t = o.t0;
      end
      CLK_T1: begin
        t = o.t1;
      end
      CLK_T2: begin
        t = o.t2;
      end
      default: begin
        t = 1'b0;
      end
    endcase
    return t;
  endfunction

  // Word-aligned address to register index; upper bits must be zero
  function automatic logic addr_ok(input logic [11:0] a, input logic [7:0] i);
    logic [11:0] want;
    want = {2'b00, i, 2'b00};
    return a == want;
  endfunction

  // Read value of one register index
  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      REF_CTRL_IDX: begin
        v = s.ref_ctrl;
      end
      B_CTRL_IDX: begin
        v = s.b_ctrl;
      end
      A_CTRL_IDX: begin
        v = s.a_ctrl;
      end
      IRQ_STAT_IDX: begin
        v = s.irq_stat;
      end
      IRQ_MASK_IDX: begin
        v = s.irq_mask;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // APB decode; the slave never stretches a transfer
  always_comb begin
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    idx = apb_req.paddr[9:2];
    hit_ref = addr_ok(apb_req.paddr, REF_CTRL_IDX);
    hit_b = addr_ok(apb_req.paddr, B_CTRL_IDX);
    hit_a = addr_ok(apb_req.paddr, A_CTRL_IDX);
    hit_stat = addr_ok(apb_req.paddr, IRQ_STAT_IDX);
    hit_mask = addr_ok(apb_req.paddr, IRQ_MASK_IDX);
    // Anything else in the window is refused with an error
    hit = hit_ref | hit_b | hit_a | hit_stat | hit_mask;
    wr_acc = access & hit & apb_req.pwrite;
    rd_acc = access & ~apb_req.pwrite;
    wbyte = apb_req.pwdata[7:0];
  end

  // Event detection for comparator B
  always_comb begin
    en = st.b_ctrl[B_EN_BIT];
    mode = st.b_ctrl[B_MODE_LSB +: 3];
    gated = en & comp_b_in;
    b_tick = sel_tick(st.ref_ctrl[B_CLK_LSB +: 2], ovf);
    a_tick = sel_tick(st.ref_ctrl[A_CLK_LSB +: 2], ovf);
    // Edges compare against the level seen at the previous tick
    rise = b_tick & gated & ~st.b_smp;
    fall = b_tick & ~gated & st.b_smp;
    // Two Timer 1 samples must agree before the settled level moves
    db_ok = ovf.t1 & (gated == st.db_raw);
    db_rise = db_ok & gated & ~st.db_val;
    db_fall = db_ok & ~gated & st.db_val;
    // Level modes fire on every tick while the level holds
    case (mode)
      MODE_LOW: begin
        cond = b_tick & ~gated;
      end
      MODE_RISE: begin
        cond = rise;
      end
      MODE_DB_TOG: begin
        cond = db_rise | db_fall;
      end
      MODE_DB_RISE: begin
        cond = db_rise;
      end
      MODE_FALL: begin
        cond = fall;
      end
      MODE_TOG: begin
        cond = rise | fall;
      end
      MODE_DB_FALL: begin
        cond = db_fall;
      end
      MODE_HIGH: begin
        cond = b_tick & gated;
      end
      default: begin
        cond = 1'b0;
      end
    endcase
    // A disabled comparator sets no flag even if stale samples would edge
    ev = en & cond;
  end

  // Next state: sampling, flag, interrupt and register writes
  always_comb begin
    nxt = st;
    // Gated output is registered so it never glitches on enable writes
    nxt.b_out = gated;
    // Edge reference, taken on the selected sampling tick
    if (b_tick) begin
      nxt.b_smp = gated;
    end
    // Debounce always paces on Timer 1, whatever the clock select says
    if (ovf.t1) begin
      nxt.db_raw = gated;
    end
    if (db_ok) begin
      nxt.db_val = gated;
    end
    // Comparator A is only sampled; its events live elsewhere
    if (a_tick) begin
      nxt.a_smp = comp_a_in;
    end
    // Setup phase: capture read data so prdata comes from a flop
    if (setup) begin
      nxt.rdata = {24'h000000, reg_read(st, idx)};
      nxt.rd_stat = 8'h00;
      if (hit_stat) begin
        nxt.rd_stat = st.irq_stat;
      end
    end
    // Only mapped words take a write; the low byte carries the value
    if (wr_acc) begin
      if (hit_ref) begin
        // Selects move at once; keeping connect low meanwhile is software's job
        nxt.ref_ctrl = wbyte;
      end
      if (hit_b) begin
        // Writing one to the flag sets it, zero clears it
        nxt.b_ctrl = wbyte;
      end
      if (hit_a) begin
        // Only the connect bit of comparator A lives here
        nxt.a_ctrl = {2'b00, wbyte[A_CONN_BIT], 5'b00000};
      end
      if (hit_mask) begin
        nxt.irq_mask = {7'b0000000, wbyte[IRQ_B_BIT]};
      end
    end
    // Read clears only bits the reader actually saw at setup
    if (rd_acc) begin
      nxt.irq_stat = st.irq_stat & ~st.rd_stat;
    end
    // Hardware set wins over a software clear in the same cycle
    if (ev) begin
      nxt.b_ctrl[B_FLAG_BIT] = 1'b1;
      nxt.irq_stat[IRQ_B_BIT] = 1'b1;
    end
    nxt.irq = |(nxt.irq_stat & nxt.irq_mask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Software-visible registers
      st.ref_ctrl <= REF_CTRL_RST;
      st.b_ctrl <= B_CTRL_RST;
      st.a_ctrl <= A_CTRL_RST;
      st.irq_stat <= 8'h00;
      st.irq_mask <= IRQ_MASK_RST;
      // Bus read path
      st.rdata <= 32'h00000000;
      st.rd_stat <= 8'h00;
      // Sampling history; cleared so no edge is seen right after reset
      st.b_out <= 1'b0;
      st.b_smp <= 1'b0;
      st.db_raw <= 1'b0;
      st.db_val <= 1'b0;
      st.a_smp <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st <= nxt;
    end
  end

  // Bus answer; zero-wait APB, error on unmapped words
  always_comb begin
    apb_rsp.prdata = st.rdata;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = access & ~hit;
  end

  // Comparator and interrupt outputs, all straight from flops
  always_comb begin
    comp_b_out = st.b_out;
    comp_a_sampled = st.a_smp;
    comparator_b_flag = st.b_ctrl[B_FLAG_BIT];
    irq = st.irq;
  end

  // Pin steering follows enable and connect bits directly
  always_comb begin
    // Positive select is not guarded; software must drop connect first
    analog_ctl.b_pos_sel = st.b_ctrl[B_POS_LSB +: 2];
    analog_ctl.b_neg_sel = st.ref_ctrl[B_NEG_LSB +: 2];
    analog_ctl.a_neg_sel = st.ref_ctrl[A_NEG_LSB +: 2];
    analog_ctl.b_connect = st.b_ctrl[B_CONN_BIT];
    analog_ctl.a_connect = st.a_ctrl[A_CONN_BIT];
    analog_ctl.pin_dig_off = {4{st.b_ctrl[B_EN_BIT]}};
    analog_ctl.pin_input_only = {4{st.b_ctrl[B_EN_BIT]}};
  end
endmodule

`default_nettype wire

/* File: verif/cmp_event_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cmp_event_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire cmp_event_pkg::apb_req_t apb_req, // Bus
  input wire logic comp_b_in, // Raw B
  input wire logic comp_b_out, // Gated B
  input wire cmp_event_pkg::analog_ctl_t analog_ctl, // Steering
  input wire logic comparator_b_flag // Flag
);
  import cmp_event_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, wr_b, wr_r, wr_b_q, wr_r_q, en;
  logic [7:0] wd_q;
  // Writes land at the access edge; outputs show them one edge later
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign wr_b = wr && apb_req.paddr == {2'h0, B_CTRL_IDX, 2'h0};
  assign wr_r = wr && apb_req.paddr == {2'h0, REF_CTRL_IDX, 2'h0};
  // Last write kept so steering can be tied to its cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= 1'b0;
      wr_b_q <= 1'b0;
      wr_r_q <= 1'b0;
      wd_q <= 8'h00;
    end else begin
      wr_b_q <= wr_b;
      wr_r_q <= wr_r;
      wd_q <= apb_req.pwdata[7:0];
      if (wr_b) begin
        en <= apb_req.pwdata[B_EN_BIT];
      end
    end
  end
  off_low_a: assert property (!en |=> !comp_b_out) else $error("B out high");
  on_pass_a: assert property (en && comp_b_in |=> comp_b_out) else $error("B out lost");
  no_flag_a:
    assert property (!en && !comparator_b_flag && !wr_b |=> !comparator_b_flag)
    else $error("flag set while off");
  flag_hold_a:
    assert property (comparator_b_flag && !wr_b |=> comparator_b_flag) else $error("flag lost");
  pin_mode_a:
    assert property (analog_ctl.pin_input_only == {4{en}} && analog_ctl.pin_dig_off == {4{en}})
    else $error("pin mode wrong");
  reset_ref_a:
    assert property ($rose(presetn) |-> {analog_ctl.b_neg_sel, analog_ctl.a_neg_sel} == 4'h0)
    else $error("ref not reset");
  b_neg_a:
    assert property (wr_r_q |-> analog_ctl.b_neg_sel == wd_q[5:4]) else $error("B neg wrong");
  a_neg_a:
    assert property (wr_r_q |-> analog_ctl.a_neg_sel == wd_q[1:0]) else $error("A neg wrong");
  b_conn_a:
    assert property (wr_b_q |-> analog_ctl.b_connect == wd_q[5]) else $error("connect wrong");
endmodule
bind comparator_event_control cmp_event_sva u_cmp_event_sva (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .comp_b_in(comp_b_in), .comp_b_out(comp_b_out),
  .analog_ctl(analog_ctl), .comparator_b_flag(comparator_b_flag));
`default_nettype wire

/* File: verif/comparator_event_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module comparator_event_control_tb_top;
  import cmp_event_pkg::*;
  logic pclk, presetn, cb, ca, bout, flag, irq, err, asmp;
  apb_req_t req;
  apb_rsp_t rsp;
  timer_ovf_t ovf;
  analog_ctl_t act;
  int n_mismatch, samples_checked;
  logic [7:0] q;
  // Each row: mode, quiet start level, expected flag after the input moves
  logic [4:0] rows [11] = '{5'h03, 5'h05, 5'h06, 5'h09, 5'h0D, 5'h0E, 5'h10, 5'h13, 5'h17,
    5'h1B, 5'h1D};
  comparator_event_control u_comparator_event_control (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .ovf(ovf), .comp_b_in(cb), .comp_a_in(ca),
    .comp_b_out(bout), .comp_a_sampled(asmp), .analog_ctl(act), .comparator_b_flag(flag),
    .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Timers overflow every fourth cycle; A moves just after, so its tick choice shows
  initial begin
    ovf = '0;
    ca = 1'b0;
    forever begin
      repeat (3) @(posedge pclk);
      ovf <= 3'h7;
      @(posedge pclk);
      ovf <= 3'h0;
      ca <= ~ca;
    end
  end
  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // One APB transfer, then one idle cycle so the release never meets a new setup
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, {2'h0, a, 2'h0}, {24'h0, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 9);
    if (n > 8) begin
      n_mismatch++;
      close_out();
    end
    q = rsp.prdata[7:0];
    err = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    req = '0;
    cb = 1'b0;
    err = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(1'b0, REF_CTRL_IDX, 8'h00);
    chk(q, REF_CTRL_RST);
    acc(1'b0, B_CTRL_IDX, 8'h00);
    chk(q, B_CTRL_RST);
    acc(1'b0, 8'h10, 8'h00);
    chk({err, q[6:0]}, 8'h80);
    // Connect stays low while the selects move
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, REF_CTRL_IDX, {4{c[1:0]}});
      acc(1'b0, REF_CTRL_IDX, 8'h00);
      chk(q, {4{c[1:0]}});
      if (c == 2) chk({7'h0, asmp ^ ca}, 8'h01);
      chk({4'h0, act.b_neg_sel, act.a_neg_sel}, {4'h0, c[1:0], c[1:0]});
    end
    acc(1'b1, REF_CTRL_IDX, 8'h00);
    acc(1'b1, B_CTRL_IDX, 8'h80);
    acc(1'b1, B_CTRL_IDX, 8'hA0);
    acc(1'b1, A_CTRL_IDX, 8'h20);
    chk({4'h0, act.b_pos_sel, act.b_connect, act.a_connect}, 8'h0B);
    acc(1'b1, B_CTRL_IDX, 8'h80);
    acc(1'b1, IRQ_MASK_IDX, 8'h01);
    // Arm at a quiet level, clear the flag, then move the input
    foreach (rows[i]) begin
      cb <= rows[i][1];
      acc(1'b1, B_CTRL_IDX, {5'h01, rows[i][4:2]});
      repeat (16) @(posedge pclk);
      acc(1'b1, B_CTRL_IDX, {5'h01, rows[i][4:2]});
      chk({7'h0, flag}, 8'h00);
      cb <= ~rows[i][1];
      repeat (16) @(posedge pclk);
      chk({7'h0, flag}, {7'h0, rows[i][0]});
    end
    chk({7'h0, irq}, 8'h01);
    acc(1'b1, B_CTRL_IDX, 8'h88);
    acc(1'b1, B_CTRL_IDX, 8'h80);
    acc(1'b0, IRQ_STAT_IDX, 8'h00);
    chk(q, 8'h01);
    acc(1'b0, IRQ_STAT_IDX, 8'h00);
    chk({q[6:0], irq}, 8'h00);
    cb <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({6'h0, flag, bout}, 8'h00);
    acc(1'b1, IRQ_MASK_IDX, 8'h00);
    acc(1'b1, B_CTRL_IDX, 8'h88);
    repeat (4) @(posedge pclk);
    chk({6'h0, flag, irq}, 8'h02);
    close_out();
  end
endmodule
`default_nettype wire
